// [rtl/fpc_classify.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fpc_regs.svh"
module fpc_classify
	import fpc_pkg::*;
(
	input  wire logic [79:0] value,
	output fpc_class_t       cls,
	output logic             is_qnan,
	output logic             is_snan
);
	logic [14:0] exp_f;
	logic [63:0] sig_f;

	assign exp_f = value[78:64];
	assign sig_f = value[63:0];

	// sort an extended-real encoding into its class
	always_comb begin
		if (exp_f == 15'h0000) begin
			cls = (sig_f == 64'h0) ? FPC_CL_ZERO : FPC_CL_DENORM;
		end else if (exp_f == `FPC_EXP_MAX) begin
			if (!sig_f[63])
				cls = FPC_CL_UNSUP;
			else if (sig_f[62:0] == 63'h0)
				cls = FPC_CL_INF;
			else
				cls = FPC_CL_NAN;
		end else begin
			cls = sig_f[63] ? FPC_CL_NORMAL : FPC_CL_UNSUP; // unnormals unsupported
		end
		is_qnan = (cls == FPC_CL_NAN) && sig_f[62];
		is_snan = (cls == FPC_CL_NAN) && !sig_f[62];
	end
endmodule
`default_nettype wire

// [rtl/fpc_compare_classify.sv]
// Behaviour
// - each compare yields less, equal, greater or unordered
// - status cc bits 000 gt, 001 lt, 100 eq, 111 unordered
// - ordered compares flag invalid on unordered
// - popping compares pop once or twice afterwards
// - unordered compares stay quiet on quiet NaN
// - integer source converted first, pop variant pops once
// - zero test compares against positive zero
// - flag compares write zero, parity, carry flags
// - unordered flag compares quiet; pop variants pop once
// - examine classifies top value into condition bits
// - examine puts top value sign in cc_bit1
// - no direct branch on condition bits here
// - mask 0400H isolates the unordered bit
// - pop marks top empty and increments top pointer
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "fpc_regs.svh"
module fpc_compare_classify
	import fpc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	output logic             busy,
	output logic      [15:0] status_word,
	output logic             zero_flag,
	output logic             parity_flag,
	output logic             carry_flag
);
	fpc_state_t  state_q;
	fpc_op_t     op_q;
	logic [1:0]  pops_q;
	logic [79:0] opa_q;
	logic [79:0] opb_q;
	logic [31:0] int_q;
	logic [15:0] sw_q;
	logic [7:0]  tag_q;
	logic [7:0]  iflags_q;
	logic [1:0]  irq_stat_q;
	logic [1:0]  irq_mask_q;
	logic [31:0] rdata_q;
	logic [79:0] int_ext;
	logic [79:0] opnd   [2];
	fpc_class_t  cls    [2];
	logic        qnan   [2];
	logic        snan   [2];
	fpc_rel_t    rel;
	logic        inv_evt;
	logic        done_evt;
	logic [2:0]  code;
	logic [2:0]  top;
	logic        wr_acc;
	logic        setup_rd;
	logic        exec;

	function automatic logic addr_hit(input logic [7:0] a);
		return (a <= `FPC_ADDR_IRQ_MASK) && (a[1:0] == 2'b00);
	endfunction

	// condition pattern {high, middle, low} for a relation
	function automatic logic [2:0] code_of(input fpc_rel_t r);
		case (r)
			FPC_REL_GT: return 3'b000;
			FPC_REL_LT: return 3'b001;
			FPC_REL_EQ: return 3'b100;
			default:    return 3'b111;
		endcase
	endfunction

	function automatic logic [1:0] pops_of(input fpc_op_t o);
		case (o)
			FPC_OP_CMP_ORD_P2, FPC_OP_CMP_UNORD_P2: return 2'd2;
			FPC_OP_CMP_ORD_P, FPC_OP_CMP_UNORD_P, FPC_OP_CMP_INT_P,
			FPC_OP_FLAGS_P, FPC_OP_FLAGS_UN_P:      return 2'd1;
			default:                                return 2'd0;
		endcase
	endfunction

	function automatic logic is_quiet(input fpc_op_t o);
		return (o == FPC_OP_CMP_UNORD) || (o == FPC_OP_CMP_UNORD_P) ||
			(o == FPC_OP_CMP_UNORD_P2) || (o == FPC_OP_FLAGS_UN) ||
			(o == FPC_OP_FLAGS_UN_P);
	endfunction

	function automatic logic is_flags(input fpc_op_t o);
		return (o == FPC_OP_FLAGS) || (o == FPC_OP_FLAGS_P) ||
			(o == FPC_OP_FLAGS_UN) || (o == FPC_OP_FLAGS_UN_P);
	endfunction

	// apb handshake: zero wait states
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !addr_hit(paddr);
	assign wr_acc   = psel && penable && pwrite && addr_hit(paddr);
	assign setup_rd = psel && !penable && !pwrite;
	assign prdata   = rdata_q;
	assign exec     = (state_q == FPC_ST_EXEC);
	assign top      = sw_q[`FPC_SW_TOP_HI:`FPC_SW_TOP_LO];
	assign busy     = (state_q != FPC_ST_IDLE);

	// outputs toward the integer unit
	assign status_word = sw_q;
	assign zero_flag   = iflags_q[`FPC_IF_ZF];
	assign parity_flag = iflags_q[`FPC_IF_PF];
	assign carry_flag  = iflags_q[`FPC_IF_CF];
	assign irq         = |(irq_stat_q & irq_mask_q);

	// read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h0;
		end else if (setup_rd) begin
			case (paddr)
				`FPC_ADDR_CMD:       rdata_q <= {27'h0, busy, op_q};
				`FPC_ADDR_OPA_LO:    rdata_q <= opa_q[31:0];
				`FPC_ADDR_OPA_HI:    rdata_q <= opa_q[63:32];
				`FPC_ADDR_OPA_EXP:   rdata_q <= {16'h0, opa_q[79:64]};
				`FPC_ADDR_OPB_LO:    rdata_q <= opb_q[31:0];
				`FPC_ADDR_OPB_HI:    rdata_q <= opb_q[63:32];
				`FPC_ADDR_OPB_EXP:   rdata_q <= {16'h0, opb_q[79:64]};
				`FPC_ADDR_INT_SRC:   rdata_q <= int_q;
				`FPC_ADDR_STATUS_W:  rdata_q <= {16'h0, sw_q};
				`FPC_ADDR_TAG:       rdata_q <= {24'h0, tag_q};
				`FPC_ADDR_INT_FLAGS: rdata_q <= {24'h0, iflags_q};
				`FPC_ADDR_IRQ_STAT:  rdata_q <= {30'h0, irq_stat_q};
				`FPC_ADDR_IRQ_MASK:  rdata_q <= {30'h0, irq_mask_q};
				default:             rdata_q <= 32'h0;
			endcase
		end
	end

	// operand registers, frozen while an operation runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opa_q <= 80'h0;
			opb_q <= 80'h0;
			int_q <= 32'h0;
		end else if (wr_acc && !busy) begin
			case (paddr)
				`FPC_ADDR_OPA_LO:  opa_q[31:0]  <= pwdata;
				`FPC_ADDR_OPA_HI:  opa_q[63:32] <= pwdata;
				`FPC_ADDR_OPA_EXP: opa_q[79:64] <= pwdata[15:0];
				`FPC_ADDR_OPB_LO:  opb_q[31:0]  <= pwdata;
				`FPC_ADDR_OPB_HI:  opb_q[63:32] <= pwdata;
				`FPC_ADDR_OPB_EXP: opb_q[79:64] <= pwdata[15:0];
				`FPC_ADDR_INT_SRC: int_q        <= pwdata;
				default:           ;
			endcase
		end
	end

	// integer source into extended real
	fpc_int2ext u_int2ext (
		.ival (int_q),
		.ext  (int_ext)
	);

	// second operand select
	always_comb begin
		opnd[0] = opa_q;
		case (op_q)
			FPC_OP_CMP_INT, FPC_OP_CMP_INT_P: opnd[1] = int_ext;
			FPC_OP_CMP_ZERO:                  opnd[1] = 80'h0;
			default:                          opnd[1] = opb_q;
		endcase
	end

	// one classifier per operand
	for (genvar g = 0; g < 2; g++) begin : g_cls
		fpc_classify u_cls (
			.value   (opnd[g]),
			.cls     (cls[g]),
			.is_qnan (qnan[g]),
			.is_snan (snan[g])
		);
	end

	// relation of the two operands
	always_comb begin
		logic [14:0] ea;
		logic [14:0] eb;
		logic        gt_mag;
		ea     = (opnd[0][78:64] == 15'h0000) ? 15'h0001 : opnd[0][78:64];
		eb     = (opnd[1][78:64] == 15'h0000) ? 15'h0001 : opnd[1][78:64];
		gt_mag = {ea, opnd[0][63:0]} > {eb, opnd[1][63:0]};
		if (cls[0] inside {FPC_CL_NAN, FPC_CL_UNSUP} ||
			cls[1] inside {FPC_CL_NAN, FPC_CL_UNSUP})
			rel = FPC_REL_UN;
		else if (cls[0] == FPC_CL_ZERO && cls[1] == FPC_CL_ZERO)
			rel = FPC_REL_EQ;
		else if (opnd[0][79] != opnd[1][79])
			rel = opnd[0][79] ? FPC_REL_LT : FPC_REL_GT;
		else if ({ea, opnd[0][63:0]} == {eb, opnd[1][63:0]})
			rel = FPC_REL_EQ;
		else
			rel = (gt_mag ^ opnd[0][79]) ? FPC_REL_GT : FPC_REL_LT;
	end

	// invalid event and condition pattern of the running operation
	always_comb begin
		if (op_q == FPC_OP_EXAMINE)
			inv_evt = 1'b0;
		else if (is_quiet(op_q))
			inv_evt = snan[0] || snan[1] || (cls[0] == FPC_CL_UNSUP) ||
				(cls[1] == FPC_CL_UNSUP);
		else
			inv_evt = (rel == FPC_REL_UN);
		inv_evt = exec && inv_evt;
		if (op_q == FPC_OP_EXAMINE)
			code = tag_q[top] ? FPC_CL_EMPTY : cls[0];
		else
			code = code_of(rel);
		done_evt = (exec && pops_of(op_q) == 2'd0) ||
			(state_q == FPC_ST_POP && pops_q == 2'd1);
	end

	// sequencer: idle, execute, then pops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= FPC_ST_IDLE;
			op_q    <= FPC_OP_NONE;
			pops_q  <= 2'd0;
		end else begin
			case (state_q)
				FPC_ST_IDLE: begin
					if (wr_acc && paddr == `FPC_ADDR_CMD &&
						pwdata[3:0] != FPC_OP_NONE &&
						pwdata[3:0] <= FPC_OP_EXAMINE) begin
						op_q    <= fpc_op_t'(pwdata[3:0]);
						state_q <= FPC_ST_EXEC;
					end
				end
				FPC_ST_EXEC: begin
					pops_q  <= pops_of(op_q);
					state_q <= (pops_of(op_q) != 2'd0) ? FPC_ST_POP : FPC_ST_IDLE;
				end
				FPC_ST_POP: begin
					pops_q <= pops_q - 2'd1;
					if (pops_q == 2'd1)
						state_q <= FPC_ST_IDLE;
				end
				default: state_q <= FPC_ST_IDLE;
			endcase
		end
	end

	// status word: software load, results, pops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_q <= `FPC_SW_RST;
		end else if (wr_acc && !busy && paddr == `FPC_ADDR_STATUS_W) begin
			sw_q <= pwdata[15:0];
		end else if (exec) begin
			if (!is_flags(op_q)) begin
				sw_q[`FPC_SW_C3] <= code[2];
				sw_q[`FPC_SW_C2] <= code[1];
				sw_q[`FPC_SW_C0] <= code[0];
				sw_q[`FPC_SW_C1] <= (op_q == FPC_OP_EXAMINE) && opa_q[79];
			end
			if (inv_evt)
				sw_q[`FPC_SW_IE] <= 1'b1;
		end else if (state_q == FPC_ST_POP) begin
			sw_q[`FPC_SW_TOP_HI:`FPC_SW_TOP_LO] <= top + 3'd1;
		end
	end

	// tag word: one bit per stack slot, set means empty
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tag_q <= `FPC_TAG_RST;
		else if (wr_acc && !busy && paddr == `FPC_ADDR_TAG)
			tag_q <= pwdata[7:0];
		else if (state_q == FPC_ST_POP)
			tag_q[top] <= 1'b1;
	end

	// integer flags written by flag compares
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			iflags_q <= `FPC_IF_RST;
		end else if (exec && is_flags(op_q)) begin
			iflags_q[`FPC_IF_ZF] <= code[2];
			iflags_q[`FPC_IF_PF] <= code[1];
			iflags_q[`FPC_IF_CF] <= code[0];
		end
	end

	// sticky interrupt status, set beats write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= `FPC_IRQ_RST;
			irq_mask_q <= `FPC_IRQ_RST;
		end else begin
			irq_stat_q <= (irq_stat_q &
				~((wr_acc && paddr == `FPC_ADDR_IRQ_STAT) ? pwdata[1:0] : 2'h0)) |
				{inv_evt, done_evt};
			if (wr_acc && paddr == `FPC_ADDR_IRQ_MASK)
				irq_mask_q <= pwdata[1:0];
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_unord_nan: assert property ((exec && cls[0] == FPC_CL_NAN) |-> rel == FPC_REL_UN)
		else $error("nan operand not unordered");
	a_cc_unord: assert property ((exec && !is_flags(op_q) && op_q != FPC_OP_EXAMINE &&
		rel == FPC_REL_UN) |=> sw_q[14] && sw_q[10] && sw_q[8])
		else $error("unordered pattern wrong");
	a_cc_less: assert property ((exec && !is_flags(op_q) && op_q != FPC_OP_EXAMINE &&
		rel == FPC_REL_LT) |=> !sw_q[14] && !sw_q[10] && sw_q[8])
		else $error("less pattern wrong");
	a_ordered_inv: assert property ((exec && !is_quiet(op_q) && op_q != FPC_OP_EXAMINE &&
		rel == FPC_REL_UN) |=> irq_stat_q[1] && sw_q[0])
		else $error("ordered unordered not invalid");
	a_pop_twice: assert property ((exec && pops_of(op_q) == 2'd2) |->
		##3 (top == 3'($past(top, 3) + 3'd2)) && !busy)
		else $error("double pop wrong");
	a_quiet_qnan: assert property ((exec && is_quiet(op_q) && (qnan[0] || qnan[1]) &&
		!snan[0] && !snan[1] && cls[0] != FPC_CL_UNSUP && cls[1] != FPC_CL_UNSUP)
		|=> irq_stat_q[1] == $past(irq_stat_q[1]) && sw_q[0] == $past(sw_q[0]))
		else $error("quiet nan raised invalid");
	a_zero_test: assert property ((exec && op_q == FPC_OP_CMP_ZERO &&
		cls[0] == FPC_CL_NORMAL && opa_q[79]) |=> sw_q[8] && !sw_q[14])
		else $error("negative not below zero");
	a_flags_equal: assert property ((exec && is_flags(op_q) && rel == FPC_REL_EQ)
		|=> zero_flag && !parity_flag && !carry_flag)
		else $error("equal flags wrong");
	a_exam_sign: assert property ((exec && op_q == FPC_OP_EXAMINE)
		|=> sw_q[9] == $past(opa_q[79]))
		else $error("examine sign wrong");
	a_pop_empty: assert property ((state_q == FPC_ST_POP) |=> tag_q[$past(top)])
		else $error("popped slot not empty");

	c_flags_unord: cover property (exec && op_q == FPC_OP_FLAGS_UN && rel == FPC_REL_UN);
	c_examine: cover property (exec && op_q == FPC_OP_EXAMINE && code == FPC_CL_EMPTY);
	c_pop_two: cover property (exec && op_q == FPC_OP_CMP_ORD_P2 ##3 irq_stat_q[0]);
endmodule
`default_nettype wire

// [rtl/fpc_int2ext.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fpc_regs.svh"
module fpc_int2ext (
	input  wire logic [31:0] ival,
	output logic      [79:0] ext
);
	// exact conversion of a signed integer to extended real
	always_comb begin
		logic [31:0] mag;
		logic [4:0]  hb;
		logic [63:0] sig;
		mag = ival[31] ? (~ival + 32'h1) : ival;
		hb  = 5'h00;
		sig = 64'h0;
		for (int i = 0; i < 32; i++) begin
			if (mag[i])
				hb = i[4:0];
		end
		sig = {mag, 32'h0} << (5'd31 - hb);
		if (mag == 32'h0)
			ext = 80'h0;
		else
			ext = {ival[31], `FPC_EXP_BIAS + {10'h000, hb}, sig};
	end
endmodule
`default_nettype wire

// [rtl/fpc_pkg.sv]
package fpc_pkg;
	typedef enum logic [3:0] {
		FPC_OP_NONE         = 4'b0000,
		FPC_OP_CMP_ORD      = 4'b0001,
		FPC_OP_CMP_ORD_P    = 4'b0010,
		FPC_OP_CMP_ORD_P2   = 4'b0011,
		FPC_OP_CMP_UNORD    = 4'b0100,
		FPC_OP_CMP_UNORD_P  = 4'b0101,
		FPC_OP_CMP_UNORD_P2 = 4'b0110,
		FPC_OP_CMP_INT      = 4'b0111,
		FPC_OP_CMP_INT_P    = 4'b1000,
		FPC_OP_FLAGS        = 4'b1001,
		FPC_OP_FLAGS_P      = 4'b1010,
		FPC_OP_FLAGS_UN     = 4'b1011,
		FPC_OP_FLAGS_UN_P   = 4'b1100,
		FPC_OP_CMP_ZERO     = 4'b1101,
		FPC_OP_EXAMINE      = 4'b1110
	} fpc_op_t;
	typedef enum logic [1:0] {
		FPC_ST_IDLE = 2'b00,
		FPC_ST_EXEC = 2'b01,
		FPC_ST_POP  = 2'b10
	} fpc_state_t;
	// code equals {cc_bit3, cc_bit2, cc_bit0} for the examine operation
	typedef enum logic [2:0] {
		FPC_CL_UNSUP  = 3'b000,
		FPC_CL_NAN    = 3'b001,
		FPC_CL_NORMAL = 3'b010,
		FPC_CL_INF    = 3'b011,
		FPC_CL_ZERO   = 3'b100,
		FPC_CL_EMPTY  = 3'b101,
		FPC_CL_DENORM = 3'b110
	} fpc_class_t;
	typedef enum logic [1:0] {
		FPC_REL_GT = 2'b00,
		FPC_REL_LT = 2'b01,
		FPC_REL_EQ = 2'b10,
		FPC_REL_UN = 2'b11
	} fpc_rel_t;
endpackage

// [rtl/fpc_regs.svh]
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH
// register byte offsets
`define FPC_ADDR_CMD       8'h00
`define FPC_ADDR_OPA_LO    8'h04
`define FPC_ADDR_OPA_HI    8'h08
`define FPC_ADDR_OPA_EXP   8'h0C
`define FPC_ADDR_OPB_LO    8'h10
`define FPC_ADDR_OPB_HI    8'h14
`define FPC_ADDR_OPB_EXP   8'h18
`define FPC_ADDR_INT_SRC   8'h1C
`define FPC_ADDR_STATUS_W  8'h20
`define FPC_ADDR_TAG       8'h24
`define FPC_ADDR_INT_FLAGS 8'h28
`define FPC_ADDR_IRQ_STAT  8'h2C
`define FPC_ADDR_IRQ_MASK  8'h30
// status word fields
`define FPC_SW_IE          0
`define FPC_SW_C0          8
`define FPC_SW_C1          9
`define FPC_SW_C2          10
`define FPC_SW_TOP_LO      11
`define FPC_SW_TOP_HI      13
`define FPC_SW_C3          14
// integer flags fields
`define FPC_IF_CF          0
`define FPC_IF_PF          2
`define FPC_IF_ZF          6
// interrupt status fields
`define FPC_IRQ_DONE       0
`define FPC_IRQ_INV        1
// reset values
`define FPC_SW_RST         16'h0000
`define FPC_TAG_RST        8'hFF
`define FPC_IF_RST         8'h00
`define FPC_IRQ_RST        2'h0
// extended-real encoding
`define FPC_EXP_BIAS       15'h3FFF
`define FPC_EXP_MAX        15'h7FFF
`endif

// [testbench/fpc_compare_classify_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fpc_regs.svh"
module fpc_compare_classify_tb_top;
	import fpc_pkg::*;
	localparam logic [79:0] V_ONE  = {16'h3FFF, 64'h8000_0000_0000_0000};
	localparam logic [79:0] V_TWO  = {16'h4000, 64'h8000_0000_0000_0000};
	localparam logic [79:0] V_MONE = {16'hBFFF, 64'h8000_0000_0000_0000};
	localparam logic [79:0] V_QNAN = {16'h7FFF, 64'hC000_0000_0000_0000};
	localparam logic [79:0] V_SNAN = {16'h7FFF, 64'hA000_0000_0000_0000};
	localparam logic [79:0] V_NINF = {16'hFFFF, 64'h8000_0000_0000_0000};
	localparam logic [79:0] V_ZERO = 80'h0;
	localparam logic [79:0] V_UNSUP = {16'h3FFF, 64'h4000_0000_0000_0000};
	localparam logic [79:0] V_DEN  = {16'h0000, 64'h0000_0000_0000_0001};
	logic        pclk, presetn, psel, penable, pwrite, store_sw;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, irq, busy, zero_flag, parity_flag, carry_flag, err;
	logic [15:0] status_word, integer_accumulator;
	logic        take_unord, take_gt, take_lt, take_eq;
	int          failures, checks;

	fpc_compare_classify u_fpc_compare_classify (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .busy(busy), .status_word(status_word),
		.zero_flag(zero_flag), .parity_flag(parity_flag), .carry_flag(carry_flag)
	);
	fpc_int_unit_model u_fpc_int_unit_model (
		.pclk(pclk), .presetn(presetn), .store_sw(store_sw), .status_word(status_word),
		.integer_accumulator(integer_accumulator), .take_unord(take_unord),
		.take_gt(take_gt), .take_lt(take_lt), .take_eq(take_eq)
	);

	// free-running bus clock, 8 ns period
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic report_and_stop();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
		end
	endtask

	// one transfer: setup, then access held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			failures++;
			report_and_stop();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		apb(1'b0, a, 32'h0, q, err);
	endtask

	// load operands, start one operation, wait for it and check every result
	task automatic tc(input logic [3:0] op, input logic [79:0] a, input logic [79:0] b,
			input logic [31:0] isrc, input logic [7:0] tag0, input logic [15:0] sw,
			input logic [2:0] fl, input logic [7:0] tag, input int cyc);
		int          n;
		logic [31:0] q;
		wr(`FPC_ADDR_OPA_LO, a[31:0]);
		wr(`FPC_ADDR_OPA_HI, a[63:32]);
		wr(`FPC_ADDR_OPA_EXP, {16'h0000, a[79:64]});
		wr(`FPC_ADDR_OPB_LO, b[31:0]);
		wr(`FPC_ADDR_OPB_HI, b[63:32]);
		wr(`FPC_ADDR_OPB_EXP, {16'h0000, b[79:64]});
		wr(`FPC_ADDR_INT_SRC, isrc);
		wr(`FPC_ADDR_STATUS_W, 32'h0);
		wr(`FPC_ADDR_TAG, {24'h0, tag0});
		wr(`FPC_ADDR_CMD, {28'h0, op});
		#1;
		n = 0;
		while (busy === 1'b1 && n < 10) begin
			@(posedge pclk);
			#1;
			n++;
		end
		if (n >= 10) begin
			failures++;
			report_and_stop();
		end
		chk_word(n, cyc);
		chk_word({16'h0, status_word}, {16'h0, sw});
		rd(`FPC_ADDR_TAG, q);
		chk_word(q, {24'h0, tag});
		if (op >= 4'h9 && op <= 4'hC) begin
			chk_word({29'h0, zero_flag, parity_flag, carry_flag}, {29'h0, fl});
		end
		if (op <= 4'h8 || op == 4'hD) begin
			@(posedge pclk);
			store_sw <= 1'b1;
			@(posedge pclk);
			store_sw <= 1'b0;
			#1;
			chk_bit(take_unord, sw[10]);
			chk_bit(take_gt, (sw & 16'h4500) == 16'h0000);
			chk_bit(take_lt, sw[8]);
			chk_bit(take_eq, sw[14]);
		end
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		store_sw = 1'b0;
		failures = 0;
		checks = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// reset values and refused addresses
		rd(`FPC_ADDR_STATUS_W, r);
		chk_word(r, 32'h0);
		rd(`FPC_ADDR_TAG, r);
		chk_word(r, 32'h0000_00FF);
		rd(`FPC_ADDR_INT_FLAGS, r);
		chk_word(r, 32'h0);
		rd(8'h40, r);
		chk_bit(err, 1'b1);
		rd(8'h02, r);
		chk_bit(err, 1'b1);
		// compares into the status word
		tc(4'h1, V_TWO, V_ONE, 0, 8'h00, 16'h0000, 3'b000, 8'h00, 1);
		tc(4'h2, V_ONE, V_TWO, 0, 8'h00, 16'h0900, 3'b000, 8'h01, 2);
		tc(4'h3, V_ONE, V_ONE, 0, 8'h00, 16'h5000, 3'b000, 8'h03, 3);
		tc(4'h1, V_QNAN, V_ONE, 0, 8'h00, 16'h4501, 3'b000, 8'h00, 1);
		tc(4'h4, V_QNAN, V_ONE, 0, 8'h00, 16'h4500, 3'b000, 8'h00, 1);
		tc(4'h5, V_SNAN, V_ONE, 0, 8'h00, 16'h4D01, 3'b000, 8'h01, 2);
		tc(4'h6, V_ONE, V_TWO, 0, 8'h00, 16'h1100, 3'b000, 8'h03, 3);
		tc(4'h4, V_UNSUP, V_ONE, 0, 8'h00, 16'h4501, 3'b000, 8'h00, 1);
		tc(4'h7, V_ONE, V_ZERO, 2, 8'h00, 16'h0100, 3'b000, 8'h00, 1);
		tc(4'h8, V_TWO, V_ZERO, 2, 8'h00, 16'h4800, 3'b000, 8'h01, 2);
		tc(4'hD, V_MONE, V_TWO, 0, 8'h00, 16'h0100, 3'b000, 8'h00, 1);
		// compares into the integer flags
		tc(4'h9, V_TWO, V_ONE, 0, 8'h00, 16'h0000, 3'b000, 8'h00, 1);
		tc(4'hA, V_ONE, V_TWO, 0, 8'h00, 16'h0800, 3'b001, 8'h01, 2);
		tc(4'hB, V_ONE, V_ONE, 0, 8'h00, 16'h0000, 3'b100, 8'h00, 1);
		tc(4'hC, V_QNAN, V_ONE, 0, 8'h00, 16'h0800, 3'b111, 8'h01, 2);
		tc(4'h9, V_QNAN, V_ONE, 0, 8'h00, 16'h0001, 3'b111, 8'h00, 1);
		// classification of the stack top
		tc(4'hE, V_NINF, V_ONE, 0, 8'h00, 16'h0700, 3'b000, 8'h00, 1);
		tc(4'hE, V_ONE, V_ONE, 0, 8'h01, 16'h4100, 3'b000, 8'h01, 1);
		tc(4'hE, V_ZERO, V_ONE, 0, 8'h00, 16'h4000, 3'b000, 8'h00, 1);
		tc(4'hE, V_MONE, V_ONE, 0, 8'h00, 16'h0600, 3'b000, 8'h00, 1);
		tc(4'hE, V_UNSUP, V_ONE, 0, 8'h00, 16'h0000, 3'b000, 8'h00, 1);
		tc(4'hE, V_QNAN, V_ONE, 0, 8'h00, 16'h0100, 3'b000, 8'h00, 1);
		tc(4'hE, V_DEN, V_ONE, 0, 8'h00, 16'h4400, 3'b000, 8'h00, 1);
		rd(`FPC_ADDR_CMD, r);
		chk_word(r, 32'h0000_000E);
		// interrupt: masked done, unmasked invalid, cleared by writing one
		wr(`FPC_ADDR_IRQ_STAT, 32'h3);
		wr(`FPC_ADDR_IRQ_MASK, 32'h2);
		tc(4'h1, V_TWO, V_ONE, 0, 8'h00, 16'h0000, 3'b000, 8'h00, 1);
		chk_bit(irq, 1'b0);
		tc(4'h1, V_QNAN, V_ONE, 0, 8'h00, 16'h4501, 3'b000, 8'h00, 1);
		chk_bit(irq, 1'b1);
		rd(`FPC_ADDR_IRQ_STAT, r);
		chk_word(r, 32'h3);
		wr(`FPC_ADDR_IRQ_STAT, 32'h2);
		#1;
		chk_bit(irq, 1'b0);
		report_and_stop();
	end
endmodule
`default_nettype wire

// [testbench/fpc_int_unit_model.sv]
`timescale 1ns/100ps
`default_nettype none
module fpc_int_unit_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        store_sw,
	input  wire logic [15:0] status_word,
	output logic      [15:0] integer_accumulator,
	output logic             take_unord,
	output logic             take_gt,
	output logic             take_lt,
	output logic             take_eq
);
	// copy of the status word taken right after a compare
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			integer_accumulator <= 16'h0000;
		end else if (store_sw) begin
			integer_accumulator <= status_word;
		end
	end
	// test masks decide the branches, condition bits never used directly
	assign take_unord = (integer_accumulator & 16'h0400) != 16'h0000;
	assign take_gt    = (integer_accumulator & 16'h4500) == 16'h0000;
	assign take_lt    = (integer_accumulator & 16'h0100) != 16'h0000;
	assign take_eq    = (integer_accumulator & 16'h4000) != 16'h0000;
endmodule
`default_nettype wire
